/* rtl/adc_sleep_ctl.sv */
/*
  Converter control: conversion sequencing, halt behaviour, special event
  trigger and result registers, reached over AXI4-Lite.
  Assumes a core that drives the halt level and a sampling core that answers
  each bit strobe with one result bit in the same cycle.
*/
// Decided for this implementation: register access over AXI4-Lite.
// Operation
// - Conversion continues during halt only with the RC conversion clock.
// - With RC clock, start of conversion waits one instruction cycle.
// - At completion clear the go bit and load the 10-bit result.
// - Completion during halt with interrupt enabled wakes the processor.
// - Completion during halt, interrupt off: power down, converter-on stays.
// - Halt with non-RC clock aborts and powers down; converter-on stays.
// - Reset restores registers, disables, aborts, makes analog pins analog.
// - Result pair is not initialised by reset.
// - Special event with converter on sets go and clears timer one.
// - With converter off, trigger ignored but still clears timer one.
// - Clearing go mid-conversion aborts; result pair keeps old value.
// - A conversion takes nine conversion-bit periods.
// - Justify bit aligns result left or right, zero filled.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_params.svh"
module adc_sleep_ctl #(
  parameter int RC_DIV = `RC_DIV_CYCLES
) (
  // Clock and reset.
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite slave.
  input  wire logic [11:0]              s_awaddr,
  input  wire logic                     s_awvalid,
  output logic                          s_awready,
  input  wire logic [31:0]              s_wdata,
  input  wire logic [3:0]               s_wstrb,
  input  wire logic                     s_wvalid,
  output logic                          s_wready,
  output logic [1:0]                    s_bresp,
  output logic                          s_bvalid,
  input  wire logic                     s_bready,
  input  wire logic [11:0]              s_araddr,
  input  wire logic                     s_arvalid,
  output logic                          s_arready,
  output logic [31:0]                   s_rdata,
  output logic [1:0]                    s_rresp,
  output logic                          s_rvalid,
  input  wire logic                     s_rready,
  // Core and compare unit.
  input  wire logic                     halted,
  input  wire logic [3:0]               compare_mode_bits,
  input  wire logic                     compare_event,
  output logic                          timer_one_clear,
  output logic                          wake,
  output logic                          irq,
  // Sampling core.
  output adc_ctl_pkg::sample_req_t      sample_req,
  output logic                          bit_strobe,
  input  wire adc_ctl_pkg::sample_bit_t sample_bit,
  output logic                          converter_powered,
  output logic [7:0]                    analog_pins
);
  import adc_ctl_pkg::*;

  logic [7:0]  conv_ctrl_zero, conv_ctrl_one, periph_flags, periph_enables;
  logic [7:0]  port_a_dir, interrupt_control, result_high, result_low;
  logic [7:0]  trigger_flags, trigger_mask;
  conv_state_t state;
  logic [3:0]  bit_count;
  logic [9:0]  shift;
  logic [15:0] div_count, instr_count;
  logic        tad_tick, powered_down;
  logic        aw_hold, w_hold;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  function automatic logic [7:0] reg_index(input logic [11:0] a);
    reg_index = a[9:2];
  endfunction : reg_index

  wire logic [1:0] clk_sel    = conv_ctrl_zero[`FLD_CLK_SEL];
  wire logic       rc_sel     = (clk_sel == `CLK_SEL_RC);
  wire logic       conv_on    = conv_ctrl_zero[`BIT_CONVERTER_ON];
  wire logic       go         = conv_ctrl_zero[`BIT_GO];
  wire logic [2:0] tad_sel    = {conv_ctrl_one[`BIT_CLK_HIGH], clk_sel};
  wire logic       do_write   = aw_hold && w_hold && !s_bvalid;
  wire logic [7:0] w_idx      = reg_index(aw_addr);
  wire logic       sw_clr_go  = do_write && w_idx == `IDX_CONV_CTRL_ZERO && w_strb[0] && !w_data[`BIT_GO];
  wire logic       trig_hit   = compare_event && compare_mode_bits == `SPECIAL_EVENT_CODE;
  wire logic       irq_on     = periph_enables[`BIT_IRQ_ENABLE];
  wire logic       last_bit   = state == ST_CONV && tad_tick && bit_count == `BITS_PER_CONV - 4'h1;
  wire logic       halt_abort = halted && !rc_sel && state != ST_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_IDLE) begin
      div_count <= 16'h0000;
    end else if (tad_tick) begin
      div_count <= 16'h0000;
    end else begin
      div_count <= div_count + 16'h0001;
    end
  end
  always_comb begin
    tad_tick = 1'b0;
    case (tad_sel)
      3'h0: tad_tick = div_count == `TAD_CNT_2;
      3'h4: tad_tick = div_count == `TAD_CNT_4;
      3'h1: tad_tick = div_count == `TAD_CNT_8;
      3'h5: tad_tick = div_count == `TAD_CNT_16;
      3'h2: tad_tick = div_count == `TAD_CNT_32;
      3'h6: tad_tick = div_count == `TAD_CNT_64;
      default: tad_tick = div_count == 16'(RC_DIV - 1);
    endcase
  end

  // Sequencer. The delay state lasts one instruction cycle with RC clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= ST_IDLE;
      bit_count   <= 4'h0;
      shift       <= 10'h000;
      instr_count <= 16'h0000;
    end else if (halt_abort || sw_clr_go || !conv_on) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            state       <= rc_sel ? ST_DELAY : ST_CONV;
            instr_count <= 16'h0000;
            bit_count   <= 4'h0;
          end
        end
        ST_DELAY: begin
          instr_count <= instr_count + 16'h0001;
          if (instr_count == 16'(`INSTR_CYCLES - 1)) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (tad_tick) begin
            // Nine periods fill ten bits, so the last bit settles twice.
            shift     <= last_bit ? {shift[7:0], {2{sample_bit.bit_value}}} : {shift[8:0], sample_bit.bit_value};
            bit_count <= bit_count + 4'h1;
            if (last_bit) begin
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Power-down after halted completion without interrupt.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powered_down <= 1'b0;
    end else if (!halted) begin
      powered_down <= 1'b0;
    end else if (halt_abort || (state == ST_WAIT && !irq_on)) begin
      powered_down <= 1'b1;
    end
  end
  assign converter_powered = conv_on && !powered_down;

  // No reset term here: result pair survives every reset.
  always_ff @(posedge aclk) begin
    if (state == ST_WAIT) begin
      if (conv_ctrl_one[`BIT_JUSTIFY]) begin
        result_high <= {6'h00, shift[9:8]};
        result_low  <= shift[7:0];
      end else begin
        result_high <= shift[9:2];
        result_low  <= {shift[1:0], 6'h00};
      end
    end else if (do_write && w_strb[0] && w_idx == `IDX_RESULT_HIGH) begin
      result_high <= w_data[7:0];
    end else if (do_write && w_strb[0] && w_idx == `IDX_RESULT_LOW) begin
      result_low <= w_data[7:0];
    end
  end

  // Register reset and control writes; trigger and completion win.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_ctrl_zero    <= `RST_CONV_CTRL_ZERO;
      conv_ctrl_one     <= `RST_CONV_CTRL_ONE;
      periph_enables    <= `RST_PERIPH_ENABLES;
      port_a_dir        <= `RST_PORT_A_DIR;
      interrupt_control <= `RST_INTERRUPT_CTRL;
      trigger_mask      <= `RST_TRIGGER;
    end else begin
      if (do_write && w_strb[0]) begin
        case (w_idx)
          `IDX_CONV_CTRL_ZERO: conv_ctrl_zero    <= w_data[7:0] & `MASK_CONV_CTRL_ZERO;
          `IDX_CONV_CTRL_ONE:  conv_ctrl_one     <= w_data[7:0] & `MASK_CONV_CTRL_ONE;
          `IDX_PERIPH_ENABLES: periph_enables    <= w_data[7:0];
          `IDX_PORT_A_DIR:     port_a_dir        <= w_data[7:0];
          `IDX_INTERRUPT_CTRL: interrupt_control <= w_data[7:0];
          `IDX_SIDEBAND:       trigger_mask      <= w_data[7:0];
          default: ;
        endcase
      end
      if (trig_hit && conv_on) begin
        conv_ctrl_zero[`BIT_GO] <= 1'b1;
      end else if (state == ST_WAIT || halt_abort) begin
        conv_ctrl_zero[`BIT_GO] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_one_clear <= 1'b0;
    end else begin
      timer_one_clear <= trig_hit;
    end
  end

  // Sticky flags: set wins over write-one-to-clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_flags  <= `RST_PERIPH_FLAGS;
      trigger_flags <= `RST_TRIGGER;
    end else begin
      if (do_write && w_strb[0] && w_idx == `IDX_PERIPH_FLAGS) begin
        periph_flags <= periph_flags & ~w_data[7:0];
      end
      if (do_write && w_strb[0] && w_idx == `IDX_SIDEBAND + 8'h01) begin
        trigger_flags <= trigger_flags & ~w_data[7:0];
      end
      if (state == ST_WAIT) begin
        periph_flags[`BIT_DONE_FLAG] <= 1'b1;
      end
      if (trig_hit) begin
        trigger_flags[`BIT_TRIGGER_FLAG] <= 1'b1;
      end
    end
  end

  // Wake on enabled completion while halted.
  assign wake = halted && (periph_flags[`BIT_DONE_FLAG] && irq_on);
  assign irq  = (interrupt_control[`BIT_GIE] && interrupt_control[`BIT_PERIPHERAL_IRQ_ENABLE] && periph_flags[`BIT_DONE_FLAG] && irq_on)
              || |(trigger_flags & trigger_mask);

  // Analog pins follow configuration; reset makes all analog.
  assign analog_pins  = (conv_ctrl_one[`FLD_PORT_CFG] == 4'h0) ? `ANALOG_PIN_MASK
                      : `ANALOG_PIN_MASK & ~{4'h0, conv_ctrl_one[`FLD_PORT_CFG]};
  assign sample_req   = '{start: state == ST_CONV && bit_count == 4'h0, channel: conv_ctrl_zero[`FLD_CHANNEL]};
  assign bit_strobe   = state == ST_CONV && tad_tick;

  // AXI4-Lite write channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold  <= 1'b0;
      w_hold   <= 1'b0;
      s_bvalid <= 1'b0;
      aw_addr  <= 12'h000;
      w_data   <= 32'h00000000;
      w_strb   <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_hold <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (do_write) begin
        s_bvalid <= 1'b1;
        aw_hold  <= 1'b0;
        w_hold   <= 1'b0;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  assign s_awready = !aw_hold && !s_bvalid;
  assign s_wready  = !w_hold && !s_bvalid;
  assign s_bresp   = 2'h0;

  // AXI4-Lite read channel; unmapped indices read zero with OKAY.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h00000000;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      case (reg_index(s_araddr))
        `IDX_CONV_CTRL_ZERO: s_rdata <= {24'h000000, conv_ctrl_zero};
        `IDX_CONV_CTRL_ONE:  s_rdata <= {24'h000000, conv_ctrl_one};
        `IDX_PERIPH_FLAGS:   s_rdata <= {24'h000000, periph_flags};
        `IDX_PERIPH_ENABLES: s_rdata <= {24'h000000, periph_enables};
        `IDX_PORT_A_DIR:     s_rdata <= {24'h000000, port_a_dir};
        `IDX_INTERRUPT_CTRL: s_rdata <= {24'h000000, interrupt_control};
        `IDX_RESULT_HIGH:    s_rdata <= {24'h000000, result_high};
        `IDX_RESULT_LOW:     s_rdata <= {24'h000000, result_low};
        `IDX_PORT_A_PINS:    s_rdata <= {24'h000000, ~analog_pins & 8'h00};
        `IDX_SIDEBAND:       s_rdata <= {24'h000000, trigger_mask};
        default:             s_rdata <= 32'h00000000;
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
  assign s_arready = !s_rvalid;
  assign s_rresp   = 2'h0;

  logic [4:0] conv_cycles;
  always_ff @(posedge aclk) begin
    if (!aresetn || state != ST_CONV) begin
      conv_cycles <= 5'h00;
    end else if (tad_tick) begin
      conv_cycles <= conv_cycles + 5'h01;
    end
  end

  property p_rc_halt_continues;
    @(posedge aclk) disable iff (!aresetn) (halted && rc_sel && state == ST_CONV && conv_on && !sw_clr_go) |=> state != ST_IDLE;
  endproperty
  a_rc_halt_continues: assert property (p_rc_halt_continues) else $error("RC conversion stopped in halt.");
  property p_rc_delay;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_IDLE && go && rc_sel && conv_on && !halt_abort && !sw_clr_go) |=> state == ST_DELAY;
  endproperty
  a_rc_delay: assert property (p_rc_delay) else $error("RC start not delayed.");
  property p_done_clears_go;
    @(posedge aclk) disable iff (!aresetn) (state == ST_WAIT && !(trig_hit && conv_on)) |=> !go && periph_flags[`BIT_DONE_FLAG];
  endproperty
  a_done_clears_go: assert property (p_done_clears_go) else $error("Go not cleared at completion.");
  property p_wake;
    @(posedge aclk) disable iff (!aresetn) (state == ST_WAIT && halted && irq_on) |=> ##0 (wake || !halted);
  endproperty
  a_wake: assert property (p_wake) else $error("No wake on completion.");
  property p_halt_abort;
    @(posedge aclk) disable iff (!aresetn) halt_abort |=> state == ST_IDLE && conv_on == $past(conv_on) && !converter_powered;
  endproperty
  a_halt_abort: assert property (p_halt_abort) else $error("Halt abort misbehaved.");
  property p_trigger;
    @(posedge aclk) disable iff (!aresetn) trig_hit |=> timer_one_clear ##0 (go || !$past(conv_on));
  endproperty
  a_trigger: assert property (p_trigger) else $error("Trigger effect missing.");
  property p_abort_keeps_result;
    @(posedge aclk) disable iff (!aresetn) (sw_clr_go && state == ST_CONV) |=> $stable(result_high) && state == ST_IDLE;
  endproperty
  a_abort_keeps_result: assert property (p_abort_keeps_result) else $error("Abort changed result.");
  property p_nine_bits;
    @(posedge aclk) disable iff (!aresetn) (state == ST_CONV ##1 state == ST_WAIT) |-> $past(conv_cycles) == 5'h08;
  endproperty
  a_nine_bits: assert property (p_nine_bits) else $error("Conversion length wrong.");
  c_done: cover property (@(posedge aclk) disable iff (!aresetn) state == ST_WAIT);
  c_trigger: cover property (@(posedge aclk) disable iff (!aresetn) trig_hit && conv_on);
  c_halt_abort: cover property (@(posedge aclk) disable iff (!aresetn) halt_abort);
endmodule : adc_sleep_ctl
`default_nettype wire

/* rtl/adc_ctl_params.svh */
/*
  Constants for the converter control block: register offsets, field positions,
  reset values and timing figures.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH

// Register indices as printed; byte address is four times the index.
`define IDX_PORT_A_PINS      8'h05
`define IDX_INTERRUPT_CTRL   8'h0b
`define IDX_PERIPH_FLAGS     8'h0c
`define IDX_RESULT_HIGH      8'h1e
`define IDX_CONV_CTRL_ZERO   8'h1f
`define IDX_PORT_A_DIR       8'h85
`define IDX_PERIPH_ENABLES   8'h8c
`define IDX_RESULT_LOW       8'h9e
`define IDX_CONV_CTRL_ONE    8'h9f
`define IDX_SIDEBAND         8'ha0

// Reset values.
`define RST_CONV_CTRL_ZERO   8'h00
`define RST_CONV_CTRL_ONE    8'h00
`define RST_PERIPH_FLAGS     8'h00
`define RST_PERIPH_ENABLES   8'h00
`define RST_PORT_A_DIR       8'hff
`define RST_INTERRUPT_CTRL   8'h00

// Field positions.
`define BIT_CONVERTER_ON     0
`define BIT_GO               2
`define BIT_DONE_FLAG        6
`define BIT_IRQ_ENABLE       6
`define BIT_JUSTIFY          7
`define BIT_CLK_HIGH         6
`define BIT_GIE              7
`define BIT_PERIPHERAL_IRQ_ENABLE             6
`define BIT_TRIGGER_FLAG     0

// Codes.
`define CLK_SEL_RC           2'h3
`define SPECIAL_EVENT_CODE   4'hb
`define ANALOG_PIN_MASK      8'h1f
`define MASK_CONV_CTRL_ZERO  8'hfd
`define MASK_CONV_CTRL_ONE   8'hcf
`define RST_TRIGGER          8'h00

// Field ranges.
`define FLD_CLK_SEL          7:6
`define FLD_CHANNEL          5:3
`define FLD_PORT_CFG         3:0

// Divider end counts, one per system-clock conversion-bit period.
`define TAD_CNT_2            16'h0001
`define TAD_CNT_4            16'h0003
`define TAD_CNT_8            16'h0007
`define TAD_CNT_16           16'h000f
`define TAD_CNT_32           16'h001f
`define TAD_CNT_64           16'h003f

// Timing.
`define BITS_PER_CONV        4'h9
`define RESULT_BITS          10
`define RC_PERIOD_NS         4000
`define CLK_PERIOD_NS        25
`define RC_DIV_CYCLES        ((`RC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INSTR_CYCLES         4

`endif

/* rtl/adc_ctl_pkg.sv */
/*
  Types shared by the converter control block and its environment.
  Assumes the params header is on the include path.
*/
package adc_ctl_pkg;
  `include "adc_ctl_params.svh"

  typedef struct packed {
    logic       start;
    logic [2:0] channel;
  } sample_req_t;

  typedef struct packed {
    logic valid;
    logic bit_value;
  } sample_bit_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_CONV  = 4'b0100,
    ST_WAIT  = 4'b1000
  } conv_state_t;
endpackage : adc_ctl_pkg

/* bench/sample_core_model.sv */
/*
  Behavioural sampling core for the converter control bench.
  Assumes one bit strobe per conversion-bit period from the control block.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_core_model (
  // Clock.
  input  wire logic                aclk,
  // Control side.
  input  wire logic                bit_strobe,
  input  wire logic                level,
  output adc_ctl_pkg::sample_bit_t sample_bit,
  output int                       strobes
);
  import adc_ctl_pkg::*;
  // One bit per strobe.
  // Off the strobe the line shows the inverse, so a stray sample reads wrong.
  assign sample_bit = {bit_strobe, bit_strobe ? level : ~level};
  initial strobes = 0;
  always @(posedge aclk) begin
    if (bit_strobe === 1'b1) begin
      strobes <= strobes + 1;
    end
  end
endmodule : sample_core_model
`default_nettype wire

/* bench/tb.sv */
/*
  Self-checking bench for the converter control block.
  Assumes the params header on the include path and the sampling core model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_params.svh"
module tb;
  import adc_ctl_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        halted, compare_event, level, timer_one_clear, wake, irq;
  logic        bit_strobe, converter_powered;
  logic [3:0]  compare_mode_bits;
  logic [7:0]  analog_pins;
  sample_req_t sample_req;
  sample_bit_t sample_bit;
  int          strobes, n_errors, checks;

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba
  localparam logic [11:0] C0 = ba(`IDX_CONV_CTRL_ZERO);
  localparam logic [11:0] C1 = ba(`IDX_CONV_CTRL_ONE);
  localparam logic [11:0] FL = ba(`IDX_PERIPH_FLAGS);
  localparam logic [11:0] EN = ba(`IDX_PERIPH_ENABLES);
  localparam logic [11:0] RH = ba(`IDX_RESULT_HIGH);
  localparam logic [11:0] RL = ba(`IDX_RESULT_LOW);

  adc_sleep_ctl #(.RC_DIV(4)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'h1), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .halted(halted), .compare_mode_bits(compare_mode_bits), .compare_event(compare_event),
    .timer_one_clear(timer_one_clear), .wake(wake), .irq(irq),
    .sample_req(sample_req), .bit_strobe(bit_strobe), .sample_bit(sample_bit),
    .converter_powered(converter_powered), .analog_pins(analog_pins)
  );
  sample_core_model core (
    .aclk(aclk), .bit_strobe(bit_strobe), .level(level),
    .sample_bit(sample_bit), .strobes(strobes)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_errors++;
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic pa, pw;
    @(posedge aclk);
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    chk(bresp, 2'h0);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    chk(rresp, 2'h0);
    rready <= 1'b0;
  endtask : rd

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rdchk

  task automatic conv(input logic [7:0] c1, input logic [7:0] c0, input logic lvl, input logic hlt);
    logic [7:0] v;
    int s0, i;
    level <= lvl;
    wr(C1, c1);
    wr(C0, c0);
    s0 = strobes;
    wr(C0, c0 | 8'h04);
    // Halt follows the go write at once, as software must do for a halted conversion.
    if (hlt) halted <= 1'b1;
    i = 0;
    do begin
      rd(C0, v);
      i++;
    end while (v[`BIT_GO] !== 1'b0 && i < 400);
    chk(v[`BIT_GO], 1'b0);
    chk(strobes - s0, 9);
  endtask : conv

  task automatic pulse;
    @(posedge aclk);
    compare_event <= 1'b1;
    @(posedge aclk);
    compare_event <= 1'b0;
    #1;
  endtask : pulse

  task automatic t_reset;
    rdchk(C0, `RST_CONV_CTRL_ZERO);
    rdchk(C1, `RST_CONV_CTRL_ONE);
    rdchk(FL, `RST_PERIPH_FLAGS);
    rdchk(EN, `RST_PERIPH_ENABLES);
    rdchk(ba(`IDX_PORT_A_DIR), `RST_PORT_A_DIR);
    rdchk(12'hffc, 8'h00);
    chk(analog_pins, `ANALOG_PIN_MASK);
    $display("test reset done");
  endtask : t_reset

  task automatic t_justify_irq;
    conv(8'h80, 8'h01, 1'b1, 1'b0);
    rdchk(RH, 8'h03);
    rdchk(RL, 8'hff);
    rdchk(FL, 8'h40);
    wr(ba(`IDX_INTERRUPT_CTRL), 8'hc0);
    wr(EN, 8'h40);
    chk(irq, 1'b1);
    wr(EN, 8'h00);
    chk(irq, 1'b0);
    wr(EN, 8'h40);
    wr(FL, 8'h40);
    chk(irq, 1'b0);
    conv(8'h00, 8'h01, 1'b1, 1'b0);
    rdchk(RH, 8'hff);
    rdchk(RL, 8'hc0);
    chk(irq, 1'b1);
    wr(FL, 8'h40);
    $display("test justify and interrupt done");
  endtask : t_justify_irq

  task automatic t_abort;
    logic [7:0] v;
    level <= 1'b0;
    wr(C1, 8'h40);
    wr(C0, 8'h81);
    wr(C0, 8'h85);
    repeat (20) @(posedge aclk);
    wr(C0, 8'h81);
    repeat (700) @(posedge aclk);
    rdchk(RH, 8'hff);
    rdchk(RL, 8'hc0);
    rdchk(FL, 8'h00);
    wr(C1, 8'h00);
    wr(C0, 8'h85);
    chk(converter_powered, 1'b1);
    halted <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(converter_powered, 1'b0);
    rd(C0, v);
    chk(v[`BIT_CONVERTER_ON], 1'b1);
    repeat (400) @(posedge aclk);
    rdchk(RL, 8'hc0);
    rdchk(FL, 8'h00);
    halted <= 1'b0;
    wr(C0, 8'h01);
    $display("test abort done");
  endtask : t_abort

  task automatic t_halt_rc;
    conv(8'h80, 8'hc1, 1'b0, 1'b1);
    chk(wake, 1'b1);
    rdchk(RH, 8'h00);
    rdchk(RL, 8'h00);
    halted <= 1'b0;
    wr(FL, 8'h40);
    wr(EN, 8'h00);
    conv(8'h80, 8'hc1, 1'b1, 1'b1);
    chk(converter_powered, 1'b0);
    chk(wake, 1'b0);
    rdchk(C0, 8'hc1);
    rdchk(RL, 8'hff);
    halted <= 1'b0;
    $display("test halted conversion done");
  endtask : t_halt_rc

  task automatic t_trigger;
    int s0;
    wr(FL, 8'h40);
    compare_mode_bits <= `SPECIAL_EVENT_CODE;
    level <= 1'b1;
    wr(C1, 8'h80);
    wr(C0, 8'h09);
    chk(sample_req.channel, 3'h1);
    // Channel chosen and acquisition allowed before the trigger.
    repeat (20) @(posedge aclk);
    s0 = strobes;
    pulse();
    chk(timer_one_clear, 1'b1);
    @(posedge aclk);
    #1;
    chk(sample_req.start, 1'b1);
    repeat (40) @(posedge aclk);
    chk(strobes - s0, 9);
    rdchk(C0, 8'h09);
    rdchk(FL, 8'h40);
    wr(FL, 8'h40);
    wr(C0, 8'h00);
    pulse();
    chk(timer_one_clear, 1'b1);
    repeat (40) @(posedge aclk);
    rdchk(C0, 8'h00);
    rdchk(FL, 8'h00);
    compare_mode_bits <= 4'ha;
    wr(C0, 8'h01);
    pulse();
    chk(timer_one_clear, 1'b0);
    rdchk(C0, 8'h01);
    wr(ba(`IDX_SIDEBAND), 8'h01);
    chk(irq, 1'b1);
    wr(ba(`IDX_SIDEBAND + 8'h01), 8'h01);
    chk(irq, 1'b0);
    $display("test trigger done");
  endtask : t_trigger

  task automatic t_mid_reset;
    wr(C1, 8'h0e);
    wr(C0, 8'h85);
    repeat (10) @(posedge aclk);
    chk(analog_pins != `ANALOG_PIN_MASK, 1'b1);
    chk(converter_powered, 1'b1);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(C0, 8'h00);
    rdchk(C1, 8'h00);
    chk(analog_pins, `ANALOG_PIN_MASK);
    chk(converter_powered, 1'b0);
    rdchk(RH, 8'h03);
    rdchk(RL, 8'hff);
    $display("test mid-run reset done");
  endtask : t_mid_reset

  task automatic print_verdict;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, halted, compare_event, level} = 8'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    compare_mode_bits = 4'h0;
    n_errors = 0;
    checks = 0;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_justify_irq();
    t_abort();
    t_halt_rc();
    t_trigger();
    t_mid_reset();
    print_verdict();
  end

  // The run needs under 2000 cycles; ten times that means a hang.
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
